/* File: rtl/seecp_top.sv */
`timescale 1ns/1ps
module seecp_top
#(
  parameter int unsigned WRITE_CYCLES = seecp_pkg::WRITE_CYC
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic sclk,
  input  wire logic select_n,
  input  wire logic mosi,
  input  wire logic pause_n,
  input  wire logic protect_pin_n,
  output logic      miso_o,
  output logic      miso_oe,
  output logic      busy_flag,
  output logic      write_latch,
  output logic      hard_lock_mode,
  output logic      standby
);
  import seecp_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************

  // True for one of the six known command codes
  function automatic logic op_known(input logic [7:0] op);
    op_known = (op == OP_WRITE_ARM) || (op == OP_WRITE_DISARM) ||
               (op == OP_STATUS_READ) || (op == OP_STATUS_WRITE) ||
               (op == OP_ARRAY_READ) || (op == OP_ARRAY_WRITE);
  endfunction : op_known

  // True when the guard setting forbids writing this address
  function automatic logic guarded(input logic [9:0] a, input logic [1:0] g);
    case (g)
      2'b01:   guarded = (a >= GUARD_Q_BASE);
      2'b10:   guarded = (a >= GUARD_H_BASE);
      2'b11:   guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction : guarded

  // ************************************************************
  // Core domain state
  // ************************************************************
  logic                 cs_m1;
  logic                 cs_m2;
  logic                 cs_d;
  logic                 hold_m1;
  logic                 hold_m2;
  logic                 prot_m1;
  logic                 prot_m2;
  logic                 seen_high;
  logic                 clr_link;
  logic                 status_lock;
  logic [1:0]           guard_sel;
  logic [1:0]           pend_guard;
  logic                 pend_lock;
  seecp_kind_t          kind;
  logic [31:0]          wcnt;
  logic [7:0]           cmt_data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] cmt_valid;
  logic [5:0]           cmt_base;
  logic [7:0]           mem [1024];
  logic [7:0]           stat_byte;
  logic                 frame_end;
  logic                 wr_done;

  // ************************************************************
  // Link domain state
  // ************************************************************
  logic                 link_rst_n;
  logic [15:0]          cnt;
  logic [15:0]          next_cnt;
  logic [15:0]          sh;
  logic [7:0]           opcode;
  logic [7:0]           sdata;
  logic [9:0]           addr;
  logic                 bad;
  logic                 hdr_done;
  logic                 pause_hi;
  logic                 pause_now;
  logic                 drive;
  logic [7:0]           page [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid;
  logic [7:0]           stat_l1;
  logic [7:0]           stat_l2;
  logic [9:0]           rd_idx;
  logic [15:0]          rd_off;
  logic [3:0]           slot;
  logic [15:0]          wr_off;

  // ************************************************************
  // Pin synchronisers into the core clock
  // ************************************************************

  // Two flops for select, pause and protect pins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_m1   <= 1'b1;
      cs_m2   <= 1'b1;
      cs_d    <= 1'b1;
      hold_m1 <= 1'b1;
      hold_m2 <= 1'b1;
      prot_m1 <= 1'b1;
      prot_m2 <= 1'b1;
    end
    else
    begin
      cs_m1   <= select_n;
      cs_m2   <= cs_m1;
      cs_d    <= cs_m2;
      hold_m1 <= pause_n;
      hold_m2 <= hold_m1;
      prot_m1 <= protect_pin_n;
      prot_m2 <= prot_m1;
    end
  end

  // Frame ends when select is seen high after an active frame
  assign frame_end = cs_m2 && !cs_d && !clr_link;
  assign wr_done   = (kind != SEECP_WK_IDLE) && (wcnt == 32'd0);

  // Link logic is held cleared until select falls after being high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seen_high <= 1'b0;
      clr_link  <= 1'b1;
    end
    else
    begin
      if (cs_m2)
        seen_high <= 1'b1;
      if (frame_end)
        clr_link <= 1'b1;
      else if (!cs_m2 && seen_high)
        clr_link <= 1'b0;
    end
  end

  // Latch: set by arm, cleared by disarm and by finished writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      write_latch <= 1'b0;
    else if (wr_done)
      write_latch <= 1'b0;
    else if (frame_end && !bad && hold_m2 && cnt == CNT_OPCODE)
    begin
      if (opcode == OP_WRITE_ARM)
        write_latch <= 1'b1;
      else if (opcode == OP_WRITE_DISARM)
        write_latch <= 1'b0;
    end
  end

  // Self-timed write cycle launch, count and commit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      kind       <= SEECP_WK_IDLE;
      wcnt       <= 32'd0;
      pend_guard <= RST_GUARD;
      pend_lock  <= RST_STATUS_LOCK;
      cmt_valid  <= '0;
      cmt_base   <= 6'h00;
    end
    else
    begin
      case (kind)
        SEECP_WK_IDLE:
        begin
          if (frame_end && !bad && write_latch)
          begin
            if (opcode == OP_STATUS_WRITE && cnt == CNT_STATUS_W && hold_m2 && !hard_lock_mode)
            begin
              kind       <= SEECP_WK_STATUS;
              wcnt       <= 32'(WRITE_CYCLES);
              pend_guard <= {sdata[BIT_GUARD_HI], sdata[BIT_GUARD_LO]};
              pend_lock  <= sdata[BIT_LOCK];
            end
            else if (opcode == OP_ARRAY_WRITE && hdr_done && cnt[2:0] == 3'd0)
            begin
              kind      <= SEECP_WK_ARRAY;
              wcnt      <= 32'(WRITE_CYCLES);
              cmt_valid <= page_valid;
              cmt_base  <= addr[9:4];
            end
          end
        end
        SEECP_WK_STATUS, SEECP_WK_ARRAY:
        begin
          if (wcnt == 32'd0)
            kind <= SEECP_WK_IDLE;
          else
            wcnt <= wcnt - 32'd1;
        end
        default:
          kind <= SEECP_WK_IDLE;
      endcase
    end
  end

  // Page data copied out of the link at the end of the frame
  always_ff @(posedge clk)
  begin
    if (frame_end && kind == SEECP_WK_IDLE)
      cmt_data <= page;
  end

  // Non-volatile status bits, written at the end of a status cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_lock <= RST_STATUS_LOCK;
      guard_sel   <= RST_GUARD;
    end
    else if (wr_done && kind == SEECP_WK_STATUS)
    begin
      status_lock <= pend_lock;
      guard_sel   <= pend_guard;
    end
  end

  // Array storage; guarded bytes are left untouched
  always_ff @(posedge clk)
  begin
    if (wr_done && kind == SEECP_WK_ARRAY)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (cmt_valid[i] && !guarded({cmt_base, 4'(i)}, guard_sel))
          mem[{cmt_base, 4'(i)}] <= cmt_data[i];
      end
    end
  end

  // Status flags, lock mode, standby and the status byte for the link
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_flag      <= 1'b0;
      hard_lock_mode <= 1'b0;
      standby        <= 1'b1;
      stat_byte      <= 8'h00;
    end
    else
    begin
      busy_flag      <= (kind != SEECP_WK_IDLE) && !wr_done;
      hard_lock_mode <= status_lock && !prot_m2;
      standby        <= cs_m2 && (kind == SEECP_WK_IDLE);
      stat_byte      <= {status_lock, 3'b000, guard_sel, write_latch, kind != SEECP_WK_IDLE};
    end
  end

  // ************************************************************
  // Link side, clocked by the serial clock
  // ************************************************************
  assign link_rst_n = arst_n && !clr_link;
  assign next_cnt   = cnt + 16'd1;
  assign wr_off     = cnt - (CNT_HEADER - 16'd1);
  assign slot       = addr[3:0] + wr_off[6:3];

  // Status byte carried into the link by two flops per bit
  always_ff @(posedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      stat_l1 <= 8'h00;
      stat_l2 <= 8'h00;
    end
    else
    begin
      stat_l1 <= stat_byte;
      stat_l2 <= stat_l1;
    end
  end

  // Bit counter, shifter and command capture on rising edges
  always_ff @(posedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      cnt        <= 16'd0;
      sh         <= 16'h0000;
      opcode     <= 8'h00;
      sdata      <= 8'h00;
      addr       <= 10'h000;
      bad        <= 1'b0;
      hdr_done   <= 1'b0;
      pause_hi   <= 1'b0;
      page_valid <= '0;
    end
    else
    begin
      pause_hi <= !pause_n;
      if (pause_n && !bad)
      begin
        cnt <= next_cnt;
        sh  <= {sh[14:0], mosi};
        if (!hdr_done && next_cnt == CNT_OPCODE)
        begin
          opcode <= {sh[6:0], mosi};
          bad    <= !op_known({sh[6:0], mosi}) ||
                    ({sh[6:0], mosi} == OP_ARRAY_READ && stat_l2[BIT_BUSY]);
        end
        if (!hdr_done && next_cnt == CNT_STATUS_W)
          sdata <= {sh[6:0], mosi};
        if (!hdr_done && next_cnt == CNT_ADDRESS)
          addr <= {sh[8:0], mosi};
        if (!hdr_done && next_cnt == CNT_HEADER)
          hdr_done <= 1'b1;
        if ((hdr_done || next_cnt == CNT_HEADER) && next_cnt[2:0] == 3'd0 && opcode == OP_ARRAY_WRITE)
          page_valid[slot] <= 1'b1;
      end
    end
  end

  // Page buffer bytes, wrapping inside the page
  always_ff @(posedge sclk)
  begin
    if (pause_n && !bad && opcode == OP_ARRAY_WRITE && (hdr_done || next_cnt == CNT_HEADER) &&
        next_cnt[2:0] == 3'd0)
      page[slot] <= {sh[6:0], mosi};
  end

  // Pause seen by the output: follows the pin while the clock is low
  assign pause_now = sclk ? pause_hi : !pause_n;
  assign rd_off    = cnt - CNT_ADDRESS;
  assign rd_idx    = addr + rd_off[12:3];

  // Output bit launched on falling edges, most significant bit first
  always_ff @(negedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      miso_o <= 1'b0;
      drive  <= 1'b0;
    end
    else if (!pause_now)
    begin
      drive  <= 1'b0;
      miso_o <= 1'b0;
      if (!bad && opcode == OP_STATUS_READ && cnt >= CNT_OPCODE)
      begin
        drive  <= 1'b1;
        miso_o <= stat_l2[3'd7 - cnt[2:0]];
      end
      else if (!bad && opcode == OP_ARRAY_READ && (hdr_done || cnt >= CNT_ADDRESS))
      begin
        drive  <= 1'b1;
        miso_o <= mem[rd_idx][3'd7 - cnt[2:0]];
      end
    end
  end

  // Output floats when paused, idle, deselected or after a bad code
  assign miso_oe = drive && !pause_now && !bad;

endmodule : seecp_top

/* File: inc/seecp_pkg.sv */
// ************************************************************
// Constants of the serial memory command and protection front end
// ************************************************************
package seecp_pkg;

  // Command codes, one byte each
  localparam logic [7:0] OP_WRITE_ARM    = 8'h06;
  localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

  // Status byte bit positions
  localparam int BIT_BUSY     = 0;
  localparam int BIT_LATCH    = 1;
  localparam int BIT_GUARD_LO = 2;
  localparam int BIT_GUARD_HI = 3;
  localparam int BIT_LOCK     = 7;

  // Reset values of the non-volatile bits (delivery state)
  localparam logic       RST_STATUS_LOCK = 1'b0;
  localparam logic [1:0] RST_GUARD       = 2'b00;

  // Serial frame positions, counted in rising serial clock edges
  localparam logic [15:0] CNT_OPCODE   = 16'd8;
  localparam logic [15:0] CNT_STATUS_W = 16'd16;
  localparam logic [15:0] CNT_ADDRESS  = 16'd24;
  localparam logic [15:0] CNT_HEADER   = 16'd32;

  // Protected region starts for guard settings 01 and 10
  localparam logic [9:0] GUARD_Q_BASE = 10'h300;
  localparam logic [9:0] GUARD_H_BASE = 10'h200;

  // Array write buffer depth (bytes per write cycle)
  localparam int PAGE_BYTES = 16;

  // Self-timed write cycle
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned T_WRITE_US  = 5000;
  localparam int unsigned WRITE_CYC   = T_WRITE_US * CLK_MHZ;

  // Kind of self-timed cycle running
  typedef enum logic [1:0]
  {
    SEECP_WK_IDLE   = 2'b00,
    SEECP_WK_STATUS = 2'b01,
    SEECP_WK_ARRAY  = 2'b10
  } seecp_kind_t;

endpackage : seecp_pkg

/* File: verification/seecp_top_sva.sv */
`timescale 1ns/1ps
// ************************************************************
// Port checks of the serial memory front end
// ************************************************************
module seecp_top_sva
#(
  parameter int unsigned WRITE_CYCLES = 20
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic mosi,
  input wire logic pause_n,
  input wire logic protect_pin_n,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic busy_flag,
  input wire logic write_latch,
  input wire logic hard_lock_mode,
  input wire logic standby
);
  logic [31:0] busy_len;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Length of the running write cycle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      busy_len <= '0;
    else
      busy_len <= busy_flag ? busy_len + 32'h1 : '0;

  AST_OE_DESEL: assert property (select_n [*5] |-> !miso_oe)
    else $error("serial output driven while deselected");
  AST_OE_PAUSE: assert property (!pause_n |-> !miso_oe)
    else $error("serial output driven while paused");
  AST_SEL_ACTIVE: assert property (!select_n [*5] |-> !standby)
    else $error("standby while selected");
  AST_BUSY_NO_STANDBY: assert property (busy_flag |=> !standby)
    else $error("standby during a write cycle");
  AST_LATCH_CLR_END: assert property ($fell(busy_flag) |-> !write_latch)
    else $error("write latch still set after write cycle");
  AST_LATCH_SET_DESEL: assert property ($rose(write_latch) |-> $past(select_n, 2))
    else $error("write latch set while selected");
  AST_BUSY_LEN: assert property ($fell(busy_flag) |-> busy_len >= WRITE_CYCLES && busy_len <= WRITE_CYCLES + 2)
    else $error("write cycle length wrong");
  AST_BUSY_DESEL: assert property ($rose(busy_flag) |-> $past(select_n, 2))
    else $error("write cycle started while selected");
  AST_UNLOCK: assert property (protect_pin_n [*5] |-> !hard_lock_mode)
    else $error("hard lock with protect pin high");
endmodule : seecp_top_sva

bind seecp_top seecp_top_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva
(
  .clk(clk), .arst_n(arst_n), .sclk(sclk), .select_n(select_n), .mosi(mosi), .pause_n(pause_n),
  .protect_pin_n(protect_pin_n), .miso_o(miso_o), .miso_oe(miso_oe), .busy_flag(busy_flag),
  .write_latch(write_latch), .hard_lock_mode(hard_lock_mode), .standby(standby)
);

/* File: verification/seecp_spi_master.sv */
`timescale 1ns/1ps
// ************************************************************
// Bus master model on the serial link, clock idles low
// ************************************************************
module seecp_spi_master
(
  output logic      sclk,
  output logic      select_n,
  output logic      mosi,
  output logic      pause_n,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  logic last_q;

  // Idle bus
  initial
  begin
    sclk     = 1'b0;
    select_n = 1'b1;
    mosi     = 1'b0;
    pause_n  = 1'b1;
    last_q   = 1'b0;
  end

  // One clock pulse; a floating output reads as the inverse of its last level
  task automatic bitx(input logic b, output logic r);
    mosi = b;
    #62.5 sclk = 1'b1;
    r = miso_oe ? miso_o : ~last_q;
    last_q = r;
    #62.5 sclk = 1'b0;
  endtask : bitx

  // One byte, most significant bit first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
      bitx(tx[i], rx[i]);
  endtask : xfer

  task automatic sel();
    select_n = 1'b0;
    #62.5;
  endtask : sel

  // Select rises after the last rise and before any next one
  task automatic desel();
    #62.5 select_n = 1'b1;
    mosi = ~mosi;
    #250;
  endtask : desel

  // Pause edges only while the clock is low
  task automatic hold(input logic on);
    pause_n = ~on;
    #62.5;
  endtask : hold
endmodule : seecp_spi_master

/* File: verification/test_serial_eeprom_cmd_protect.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    if ((got) !== (ex)) \
      err_count++; \
  end
module test_serial_eeprom_cmd_protect;
  import seecp_pkg::*;
  logic       clk, arst_n, sclk, select_n, mosi, pause_n, protect_pin_n;
  logic       miso_o, miso_oe, busy_flag, write_latch, hard_lock_mode, standby;
  logic [7:0] s0, s1;
  logic       b;
  int         err_count, n_tests;

  seecp_top #(.WRITE_CYCLES(400)) DUT
  (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .select_n(select_n), .mosi(mosi), .pause_n(pause_n),
    .protect_pin_n(protect_pin_n), .miso_o(miso_o), .miso_oe(miso_oe), .busy_flag(busy_flag),
    .write_latch(write_latch), .hard_lock_mode(hard_lock_mode), .standby(standby)
  );
  seecp_spi_master u_master
  (
    .sclk(sclk), .select_n(select_n), .mosi(mosi), .pause_n(pause_n), .miso_o(miso_o), .miso_oe(miso_oe)
  );

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic op(input logic [7:0] code);
    u_master.sel();
    u_master.xfer(code, s0);
    u_master.desel();
  endtask : op

  task automatic wsr(input logic [7:0] v);
    u_master.sel();
    u_master.xfer(OP_STATUS_WRITE, s0);
    u_master.xfer(v, s0);
    u_master.desel();
  endtask : wsr

  // Two status bytes in one frame
  task automatic cmd_status_read();
    u_master.sel();
    u_master.xfer(OP_STATUS_READ, s0);
    u_master.xfer(8'h00, s0);
    u_master.xfer(8'h00, s1);
    u_master.desel();
  endtask : cmd_status_read

  task automatic idle();
    repeat (450)
      if (busy_flag !== 1'b0)
        @(negedge clk);
  endtask : idle

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Core clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog
  initial
  begin
    #500000;
    err_count++;
    summarize();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    err_count = 0;
    n_tests = 0;
    arst_n = 1'b0;
    protect_pin_n = 1'b1;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("busy", 1'b0, busy_flag)
    `CHK("latch", 1'b0, write_latch)
    `CHK("standby", 1'b1, standby)
    `CHK("oe", 1'b0, miso_oe)
    `CHK("lock", 1'b0, hard_lock_mode)
    $display("test reset done");
    cmd_status_read();
    `CHK("status", 8'h00, s0)
    `CHK("status again", 8'h00, s1)
    op(OP_WRITE_ARM);
    `CHK("latch", 1'b1, write_latch)
    cmd_status_read();
    `CHK("status", 8'h02, s1)
    op(OP_WRITE_DISARM);
    `CHK("latch", 1'b0, write_latch)
    $display("test arm done");
    wsr(8'h8c);
    `CHK("busy", 1'b0, busy_flag)
    op(OP_WRITE_ARM);
    u_master.sel();
    u_master.xfer(OP_STATUS_WRITE, s0);
    u_master.xfer(8'h8c, s0);
    u_master.bitx(1'b0, b);
    u_master.desel();
    `CHK("busy", 1'b0, busy_flag)
    $display("test refuse done");
    wsr(8'h8c);
    `CHK("busy", 1'b1, busy_flag)
    cmd_status_read();
    `CHK("status", 8'h03, s0)
    idle();
    `CHK("latch", 1'b0, write_latch)
    cmd_status_read();
    `CHK("status", 8'h8c, s0)
    $display("test status write done");
    @(negedge clk);
    protect_pin_n = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("lock", 1'b1, hard_lock_mode)
    op(OP_WRITE_ARM);
    wsr(8'h00);
    `CHK("busy", 1'b0, busy_flag)
    cmd_status_read();
    `CHK("status", 8'h8c, s0 & 8'hfd)
    @(negedge clk);
    protect_pin_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("lock", 1'b0, hard_lock_mode)
    op(OP_WRITE_ARM);
    wsr(8'h00);
    idle();
    cmd_status_read();
    `CHK("status", 8'h00, s0)
    $display("test lock done");
    u_master.sel();
    u_master.xfer(8'hff, s0);
    u_master.xfer(OP_WRITE_ARM, s0);
    `CHK("oe", 1'b0, miso_oe)
    u_master.desel();
    `CHK("latch", 1'b0, write_latch)
    $display("test bad opcode done");
    u_master.sel();
    u_master.xfer(OP_WRITE_ARM, s0);
    u_master.hold(1'b1);
    u_master.desel();
    u_master.hold(1'b0);
    `CHK("latch", 1'b0, write_latch)
    u_master.sel();
    for (int i = 7; i >= 4; i--)
      u_master.bitx(OP_STATUS_READ[i], b);
    u_master.hold(1'b1);
    `CHK("oe", 1'b0, miso_oe)
    u_master.bitx(1'b1, b);
    u_master.hold(1'b0);
    for (int i = 3; i >= 0; i--)
      u_master.bitx(OP_STATUS_READ[i], b);
    u_master.xfer(8'h00, s0);
    u_master.desel();
    `CHK("status", 8'h00, s0)
    $display("test pause done");
    summarize();
  end
endmodule : test_serial_eeprom_cmd_protect
